// File: inc/acg_regs.svh
// register offsets, field positions, reset values and the rule summary for the audio clock unit
// Behaviour
// - 18-bit cycles-per-field over three bytes
// - 22-bit nominal increment over three bytes
// - 6-bit master-to-bit clock ratio
// - 6-bit bit-to-frame clock ratio
// - mode bit clear: master clock field-locked
// - mode bit set: free-running, no correction
// - reference from decoder or expansion input
// - frame clock phase follows bit clock edge
// - bit clock phase follows master clock edge
`ifndef ACG_REGS_SVH
`define ACG_REGS_SVH
// ============================================================
// register subaddresses
`define ACG_CPF_LO_ADDR   8'h30
`define ACG_CPF_MID_ADDR  8'h31
`define ACG_CPF_HI_ADDR   8'h32
`define ACG_INC_LO_ADDR   8'h34
`define ACG_INC_MID_ADDR  8'h35
`define ACG_INC_HI_ADDR   8'h36
`define ACG_BDIV_ADDR     8'h38
`define ACG_FDIV_ADDR     8'h39
`define ACG_CTRL_ADDR     8'h3a
// ============================================================
// field widths and control bit positions
`define ACG_CPF_W         18
`define ACG_INC_W         22
`define ACG_DIV_W         6
`define ACG_PLL_OPEN_BIT  3
`define ACG_VREF_SEL_BIT  2
`define ACG_FPH_BIT       1
`define ACG_BPH_BIT       0
// ============================================================
// reset values and generator sizing
`define ACG_CPF_RST       18'h00000
`define ACG_INC_RST       22'h000000
`define ACG_DIV_RST       6'h00
`define ACG_CTRL_RST      4'h0
`define ACG_ACC_W         23
`define ACG_TRIM_W        14
`define ACG_TRIM_MAX      14'sh0fff
`define ACG_TRIM_MIN      -14'sh0fff
`endif

// File: inc/acg_pkg.sv
// types shared by the audio clock unit
package acg_pkg;
	// lock decision taken at each field reference
	typedef enum logic [1:0] {ACG_HOLD, ACG_SPEED_UP, ACG_SLOW_DOWN} acg_trim_dir_t;
	typedef logic [7:0] acg_byte_t;
endpackage

// File: design/acg_top.sv
// audio master clock generator with field lock and bit/frame clock dividers
`timescale 1ns/1ns
`include "acg_regs.svh"
module acg_top (
	input  wire logic              mclk,                    // 10 MHz system clock
	input  wire logic              rst_b,                   // async reset, active low
	input  wire logic              reg_wr,                  // byte register write strobe
	input  wire logic [7:0]        reg_addr,                // register subaddress
	input  wire acg_pkg::acg_byte_t reg_wdata,              // write data
	output acg_pkg::acg_byte_t     reg_rdata,               // read data, registered
	input  wire logic              decoder_vref,            // internal decoder field pulse
	input  wire logic              expansion_vref_input,    // expansion-port field pin
	output logic                   audio_master_clock_out,  // generated master clock
	output logic                   audio_bit_clock,         // serial bit clock
	output logic                   audio_frame_select_clock // channel select clock
);
	import acg_pkg::*;

	// ============================================================
	// register file
	logic [`ACG_CPF_W-1:0] cycles_per_field_count_q, cycles_per_field_count_d;
	logic [`ACG_INC_W-1:0] nominal_increment_value_q, nominal_increment_value_d;
	logic [`ACG_DIV_W-1:0] bit_clock_divider_q, bit_clock_divider_d;
	logic [`ACG_DIV_W-1:0] frame_clock_divider_q, frame_clock_divider_d;
	logic [3:0]            ctrl_q, ctrl_d;               // mode and phase bits
	acg_byte_t             rdata_q, rdata_d;

	logic pll_open_select, vref_source_select;
	logic frame_clock_phase_select, bit_clock_phase_select;
	assign pll_open_select          = ctrl_q[`ACG_PLL_OPEN_BIT];
	assign vref_source_select       = ctrl_q[`ACG_VREF_SEL_BIT];
	assign frame_clock_phase_select = ctrl_q[`ACG_FPH_BIT];
	assign bit_clock_phase_select   = ctrl_q[`ACG_BPH_BIT];

	// write decode; bytes merge into wide fields low byte first
	always_comb begin
		cycles_per_field_count_d  = cycles_per_field_count_q;
		nominal_increment_value_d = nominal_increment_value_q;
		bit_clock_divider_d       = bit_clock_divider_q;
		frame_clock_divider_d     = frame_clock_divider_q;
		ctrl_d                    = ctrl_q;
		if (reg_wr) begin
			case (reg_addr)
				`ACG_CPF_LO_ADDR:  cycles_per_field_count_d[7:0]   = reg_wdata;
				`ACG_CPF_MID_ADDR: cycles_per_field_count_d[15:8]  = reg_wdata;
				`ACG_CPF_HI_ADDR:  cycles_per_field_count_d[17:16] = reg_wdata[1:0];
				`ACG_INC_LO_ADDR:  nominal_increment_value_d[7:0]  = reg_wdata;
				`ACG_INC_MID_ADDR: nominal_increment_value_d[15:8] = reg_wdata;
				`ACG_INC_HI_ADDR:  nominal_increment_value_d[21:16] = reg_wdata[5:0];
				`ACG_BDIV_ADDR:    bit_clock_divider_d   = reg_wdata[5:0];
				`ACG_FDIV_ADDR:    frame_clock_divider_d = reg_wdata[5:0];
				`ACG_CTRL_ADDR:    ctrl_d = reg_wdata[3:0];
				default: ;                                     // other units own these
			endcase
		end
	end

	// read mux; unused upper bits and unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			`ACG_CPF_LO_ADDR:  rdata_d = cycles_per_field_count_q[7:0];
			`ACG_CPF_MID_ADDR: rdata_d = cycles_per_field_count_q[15:8];
			`ACG_CPF_HI_ADDR:  rdata_d = {6'h00, cycles_per_field_count_q[17:16]};
			`ACG_INC_LO_ADDR:  rdata_d = nominal_increment_value_q[7:0];
			`ACG_INC_MID_ADDR: rdata_d = nominal_increment_value_q[15:8];
			`ACG_INC_HI_ADDR:  rdata_d = {2'h0, nominal_increment_value_q[21:16]};
			`ACG_BDIV_ADDR:    rdata_d = {2'h0, bit_clock_divider_q};
			`ACG_FDIV_ADDR:    rdata_d = {2'h0, frame_clock_divider_q};
			`ACG_CTRL_ADDR:    rdata_d = {4'h0, ctrl_q};
			default:           rdata_d = 8'h00;
		endcase
	end

	// register file flops
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cycles_per_field_count_q  <= `ACG_CPF_RST;
			nominal_increment_value_q <= `ACG_INC_RST;
			bit_clock_divider_q       <= `ACG_DIV_RST;
			frame_clock_divider_q     <= `ACG_DIV_RST;
			ctrl_q                    <= `ACG_CTRL_RST;
			rdata_q                   <= 8'h00;
		end else begin
			cycles_per_field_count_q  <= cycles_per_field_count_d;
			nominal_increment_value_q <= nominal_increment_value_d;
			bit_clock_divider_q       <= bit_clock_divider_d;
			frame_clock_divider_q     <= frame_clock_divider_d;
			ctrl_q                    <= ctrl_d;
			rdata_q                   <= rdata_d;
		end
	end
	assign reg_rdata = rdata_q;

	// ============================================================
	// field reference: pin synchronised, then source select and edge detect
	logic xrv_meta_q, xrv_sync_q, ref_dly_q, ref_sel, field_pulse;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			xrv_meta_q <= 1'b0;
			xrv_sync_q <= 1'b0;
			ref_dly_q  <= 1'b0;
		end else begin
			xrv_meta_q <= expansion_vref_input;
			xrv_sync_q <= xrv_meta_q;
			ref_dly_q  <= ref_sel;
		end
	end
	// decoder pulse is already on mclk, so it needs no synchroniser
	assign ref_sel     = vref_source_select ? xrv_sync_q : decoder_vref;
	assign field_pulse = ref_sel && !ref_dly_q;

	// ============================================================
	// master clock: phase accumulator stepped by increment plus trim
	logic [`ACG_ACC_W-1:0]         acc_q, acc_d;
	logic signed [`ACG_TRIM_W-1:0] trim_q, trim_d;
	logic [`ACG_CPF_W-1:0]         cyc_cnt_q, cyc_cnt_d;   // master cycles this field
	logic                          audio_master_clock_out_dly_q;
	logic                          m_rise, m_fall;
	acg_trim_dir_t                 dir;

	assign m_rise = acc_q[`ACG_ACC_W-1] && !audio_master_clock_out_dly_q;
	assign m_fall = !acc_q[`ACG_ACC_W-1] && audio_master_clock_out_dly_q;

	// compare last field's count with the target; one lsb step per field
	// keeps the loop slow and stable at the cost of a long pull-in
	always_comb begin
		if (cyc_cnt_q < cycles_per_field_count_q)
			dir = ACG_SPEED_UP;
		else if (cyc_cnt_q > cycles_per_field_count_q)
			dir = ACG_SLOW_DOWN;
		else
			dir = ACG_HOLD;
	end

	// generator next state
	always_comb begin
		acc_d = acc_q + `ACG_ACC_W'(nominal_increment_value_q)
			+ `ACG_ACC_W'(unsigned'(`ACG_ACC_W'(signed'(trim_q))));
		cyc_cnt_d = cyc_cnt_q + (m_rise ? 18'h00001 : 18'h00000);
		trim_d    = trim_q;
		if (pll_open_select) begin
			trim_d = '0;
		end else if (field_pulse) begin
			unique case (dir)
				ACG_SPEED_UP:  if (trim_q != `ACG_TRIM_MAX) trim_d = trim_q + 14'sd1;
				ACG_SLOW_DOWN: if (trim_q != `ACG_TRIM_MIN) trim_d = trim_q - 14'sd1;
				ACG_HOLD:      trim_d = trim_q;
			endcase
		end
		// a rise in the pulse cycle belongs to the new field, else it would be lost
		if (field_pulse)
			cyc_cnt_d = m_rise ? 18'h00001 : 18'h00000;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q       <= '0;
			trim_q      <= '0;
			cyc_cnt_q   <= '0;
			audio_master_clock_out_dly_q <= 1'b0;
		end else begin
			acc_q       <= acc_d;
			trim_q      <= trim_d;
			cyc_cnt_q   <= cyc_cnt_d;
			audio_master_clock_out_dly_q <= acc_q[`ACG_ACC_W-1];
		end
	end
	assign audio_master_clock_out = audio_master_clock_out_dly_q;

	// ============================================================
	// bit and frame dividers; each output toggles after div selected edges
	function automatic logic [5:0] div_limit(input logic [5:0] div);
		div_limit = (div == 6'h00) ? 6'h01 : div;                       // zero acts as one
	endfunction

	logic [5:0] bcnt_q, bcnt_d, fcnt_q, fcnt_d;
	logic       bclk_q, bclk_d, fclk_q, fclk_d;
	logic       m_edge, b_edge;

	assign m_edge = bit_clock_phase_select ? m_rise : m_fall;
	assign b_edge = bit_clock_phase_select_edge(bclk_q, bclk_d, frame_clock_phase_select);

	// frame clock steps on the chosen bit clock transition
	function automatic logic bit_clock_phase_select_edge(input logic cur, input logic nxt,
		input logic rising);
		bit_clock_phase_select_edge = rising ? (!cur && nxt) : (cur && !nxt);
	endfunction

	always_comb begin
		bcnt_d = bcnt_q;
		bclk_d = bclk_q;
		if (m_edge) begin
			if (bcnt_q + 6'h01 >= div_limit(bit_clock_divider_q)) begin
				bcnt_d = 6'h00;
				bclk_d = !bclk_q;
			end else begin
				bcnt_d = bcnt_q + 6'h01;
			end
		end
	end

	always_comb begin
		fcnt_d = fcnt_q;
		fclk_d = fclk_q;
		if (b_edge) begin
			if (fcnt_q + 6'h01 >= div_limit(frame_clock_divider_q)) begin
				fcnt_d = 6'h00;
				fclk_d = !fclk_q;
			end else begin
				fcnt_d = fcnt_q + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bcnt_q <= '0;
			fcnt_q <= '0;
			bclk_q <= 1'b0;
			fclk_q <= 1'b0;
		end else begin
			bcnt_q <= bcnt_d;
			fcnt_q <= fcnt_d;
			bclk_q <= bclk_d;
			fclk_q <= fclk_d;
		end
	end
	assign audio_bit_clock          = bclk_q;
	assign audio_frame_select_clock = fclk_q;

	// ============================================================
	// checks
	property p_cpf_hi_write;
		@(posedge mclk) disable iff (!rst_b)
		(reg_wr && reg_addr == `ACG_CPF_HI_ADDR)
		|=> cycles_per_field_count_q[17:16] == $past(reg_wdata[1:0]);
	endproperty
	a_cpf_hi_write: assert property (p_cpf_hi_write) else $error("cpf high byte not stored");

	property p_inc_hi_read;
		@(posedge mclk) disable iff (!rst_b)
		(reg_wr && reg_addr == `ACG_INC_HI_ADDR) ##1 (!reg_wr && reg_addr == `ACG_INC_HI_ADDR)
		|=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f);
	endproperty
	a_inc_hi_read: assert property (p_inc_hi_read) else $error("increment readback wrong");

	property p_bdiv_store;
		@(posedge mclk) disable iff (!rst_b)
		(reg_wr && reg_addr == `ACG_BDIV_ADDR) |=> bit_clock_divider_q == $past(reg_wdata[5:0]);
	endproperty
	a_bdiv_store: assert property (p_bdiv_store) else $error("bit divider not stored");

	property p_fdiv_read;
		@(posedge mclk) disable iff (!rst_b)
		(reg_wr && reg_addr == `ACG_FDIV_ADDR) ##1 (!reg_wr && reg_addr == `ACG_FDIV_ADDR)
		|=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)};
	endproperty
	a_fdiv_read: assert property (p_fdiv_read) else $error("frame divider readback wrong");

	property p_lock_trim;
		@(posedge mclk) disable iff (!rst_b)
		(!pll_open_select && field_pulse && cyc_cnt_q < cycles_per_field_count_q
			&& trim_q != `ACG_TRIM_MAX) |=> trim_q == $past(trim_q) + 14'sd1;
	endproperty
	a_lock_trim: assert property (p_lock_trim) else $error("locked loop did not speed up");

	property p_open_no_trim;
		@(posedge mclk) disable iff (!rst_b)
		pll_open_select ##1 pll_open_select |-> trim_q == 14'sd0;
	endproperty
	a_open_no_trim: assert property (p_open_no_trim) else $error("open loop still trimmed");

	property p_ext_ref;
		@(posedge mclk) disable iff (!rst_b)
		vref_source_select && $past(vref_source_select)
		|-> field_pulse == ($past(expansion_vref_input, 2) && !$past(expansion_vref_input, 3));
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("reference source wrong");

	property p_fclk_phase;
		@(posedge mclk) disable iff (!rst_b)
		$changed(fclk_q) && $stable(ctrl_q) |-> $past(b_edge) &&
			($past(frame_clock_phase_select) ? $rose(bclk_q) : $fell(bclk_q));
	endproperty
	a_fclk_phase: assert property (p_fclk_phase) else $error("frame clock on wrong bit edge");

	property p_bclk_phase;
		@(posedge mclk) disable iff (!rst_b)
		$changed(bclk_q) |-> $past(m_edge);
	endproperty
	a_bclk_phase: assert property (p_bclk_phase) else $error("bit clock off master edge");
endmodule

// File: bench/acg_conv_model.sv
// converter-side model that measures edge ratios and phases of the audio clocks
`timescale 1ns/1ns
module acg_conv_model (
	input  wire logic        mclk,      // system clock used to sample the audio clocks
	input  wire logic        rst_b,     // async reset, active low
	input  wire logic        mck,       // master clock as seen at the converter
	input  wire logic        bck,       // serial bit clock
	input  wire logic        fck,       // channel select clock
	output logic [31:0]      m_rises,   // running count of master rising edges
	output logic [7:0]       m_per_b,   // master rises in the last bit clock half period
	output logic [7:0]       b_per_f,   // bit rises in the last frame clock half period
	output logic             m_at_b,    // master level when the bit clock last moved
	output logic             b_at_f     // bit clock level when the frame clock last moved
);
	logic       mck_p;                 // previous master level
	logic       bck_p;                 // previous bit clock level
	logic       fck_p;                 // previous frame clock level
	logic [7:0] mc;                    // master rises since last bit move
	logic [7:0] bc;                    // bit rises since last frame move
	logic       m_r;                   // master rise this cycle
	logic       b_r;                   // bit rise this cycle
	assign m_r = mck & ~mck_p;
	assign b_r = bck & ~bck_p;
	// ============================================================
	// edge counting; the rise in the move cycle is counted so phase does not skew ratios
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{mck_p, bck_p, fck_p, m_at_b, b_at_f} <= 5'h00;
			{mc, bc, m_per_b, b_per_f} <= 32'h0;
			m_rises <= 32'h0;
		end else begin
			mck_p <= mck;
			bck_p <= bck;
			fck_p <= fck;
			m_rises <= m_rises + 32'(m_r);
			// bit clock moved: close the master count
			if (bck != bck_p) begin
				m_per_b <= mc + 8'(m_r);
				mc <= 8'h00;
				m_at_b <= mck;
			end else begin
				mc <= mc + 8'(m_r);
			end
			// frame clock moved: close the bit count
			if (fck != fck_p) begin
				b_per_f <= bc + 8'(b_r);
				bc <= 8'h00;
				b_at_f <= bck;
			end else begin
				bc <= bc + 8'(b_r);
			end
		end
	end
endmodule

// File: bench/acg_top_tb.sv
// self-checking bench for the audio clock generator
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module acg_top_tb;
	import acg_pkg::*;
	logic       mclk, rst_b, reg_wr, dvref, xvref;  // stimulus
	logic [7:0] reg_addr;                          // subaddress
	acg_byte_t  reg_wdata, reg_rdata;              // register data
	logic       amck, abck, afck;                  // generated clocks
	logic [31:0] m_rises;                          // partner counters
	logic [7:0] m_per_b, b_per_f;                  // partner ratios
	logic       m_at_b, b_at_f;                    // partner phases
	int         errors, checks, n0, n;             // bookkeeping
	logic [7:0] adr [12] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39,
		8'h3a, 8'h33, 8'h37, 8'h3b};
	logic [7:0] msk [12] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f,
		8'h0f, 8'h00, 8'h00, 8'h00};
	logic [5:0] bdv [4] = '{6'h01, 6'h02, 6'h3f, 6'h03};  // bit ratios
	logic [5:0] fdv [4] = '{6'h01, 6'h03, 6'h01, 6'h02};  // frame ratios
	acg_top i_acg_top (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .decoder_vref(dvref),
		.expansion_vref_input(xvref), .audio_master_clock_out(amck),
		.audio_bit_clock(abck), .audio_frame_select_clock(afck));
	acg_conv_model i_acg_conv_model (.mclk(mclk), .rst_b(rst_b), .mck(amck), .bck(abck),
		.fck(afck), .m_rises(m_rises), .m_per_b(m_per_b), .b_per_f(b_per_f),
		.m_at_b(m_at_b), .b_at_f(b_at_f));
	// ============================================================
	// clock at 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ============================================================
	// register access tasks, one write strobe per byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// rdata follows the address one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		@(posedge mclk);
		#1 d = reg_rdata;
	endtask
	// reference toggles every cycle, so a field every 2 cycles; 14000 cycles a run,
	// since the one-lsb-per-field trim needs thousands of fields to move a few edges
	task automatic lock_run(input logic [7:0] ctl, input logic [17:0] tgt,
		input logic pin, output int cnt);
		logic [31:0] s;
		wr(8'h3a, 8'h08);  // open loop clears the trim
		wr(8'h30, tgt[7:0]);
		wr(8'h31, tgt[15:8]);
		wr(8'h32, {6'h00, tgt[17:16]});
		wr(8'h3a, ctl);
		s = m_rises;
		repeat (14000) begin
			@(posedge mclk);
			if (pin) xvref <= ~xvref;
			else dvref <= ~dvref;
		end
		cnt = int'(m_rises - s);
	endtask
	// ============================================================
	// verdict
	task automatic summarize;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watchdog sized above the ~92k cycles of the sequence
	initial begin
		repeat (98000) @(posedge mclk);
		errors++;
		summarize;
	end
	// ============================================================
	// main sequence
	initial begin
		logic [7:0] d;
		{rst_b, reg_wr, dvref, xvref, reg_addr, reg_wdata} = 20'h0;
		errors = 0;
		checks = 0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		// reset state and masked read-back, unmapped places stay zero
		foreach (adr[i]) begin
			rd(adr[i], d);
			`CHK(d, 8'h00)
		end
		for (int p = 0; p < 2; p++) begin
			foreach (adr[i]) wr(adr[i], p ? 8'h5a : 8'hff);
			foreach (adr[i]) begin
				rd(adr[i], d);
				`CHK(d, msk[i] & (p ? 8'h5a : 8'hff))
			end
		end
		// increment of 0x200000 gives a master period of exactly 4 cycles
		wr(8'h34, 8'h00);
		wr(8'h35, 8'h00);
		wr(8'h36, 8'h20);
		for (int k = 0; k < 4; k++) begin
			wr(8'h38, {2'h0, bdv[k]});
			wr(8'h39, {2'h0, fdv[k]});
			wr(8'h3a, 8'h08 | 8'(k));
			repeat (2000) @(posedge mclk);
			`CHK(m_per_b, {2'h0, bdv[k]})
			`CHK(b_per_f, {2'h0, fdv[k]})
			`CHK(m_at_b, k[0])
			`CHK(b_at_f, k[1])
		end
		// open loop reference, then locked runs pulled up, pulled down and per source
		lock_run(8'h08, 18'h3ffff, 1'b0, n0);
		lock_run(8'h00, 18'h3ffff, 1'b0, n);
		`CHK(n > n0, 1'b1)
		lock_run(8'h00, 18'h00000, 1'b0, n);
		`CHK(n < n0, 1'b1)
		lock_run(8'h08, 18'h00000, 1'b0, n);
		`CHK((n >= n0 - 1) && (n <= n0 + 1), 1'b1)
		lock_run(8'h04, 18'h3ffff, 1'b1, n);
		`CHK(n > n0, 1'b1)
		lock_run(8'h00, 18'h3ffff, 1'b1, n);
		`CHK((n >= n0 - 1) && (n <= n0 + 1), 1'b1)
		summarize;
	end
endmodule
